// ### hw/crs_consts.vh
/*
 * Constants of the CPU register set: register offsets, field positions,
 * reset values and memory map boundaries.
 * Assumes inclusion by bare name from the design file of the same block.
 */
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH

// ----------------------------------------------------------------------------
// Wishbone register byte offsets
// ----------------------------------------------------------------------------
`define CRS_OFS_PC        8'h00
`define CRS_OFS_ACC       8'h04
`define CRS_OFS_TMP       8'h08
`define CRS_OFS_IDX       8'h0C
`define CRS_OFS_EXP       8'h10
`define CRS_OFS_STK       8'h14
`define CRS_OFS_PSW       8'h18
`define CRS_OFS_ALU       8'h1C
`define CRS_OFS_DEC       8'h20
`define CRS_OFS_GPR_SEL   8'h24
`define CRS_OFS_GPR_DATA  8'h28
`define CRS_OFS_MEM_ADDR  8'h2C
`define CRS_OFS_MEM_DATA  8'h30
`define CRS_OFS_IRQ       8'h34

// ----------------------------------------------------------------------------
// Condition flag positions inside the low byte of the status word
// ----------------------------------------------------------------------------
`define CRS_BIT_H         7
`define CRS_BIT_I         6
`define CRS_BIT_IL_HI     5
`define CRS_BIT_IL_LO     4
`define CRS_BIT_N         3
`define CRS_BIT_Z         2
`define CRS_BIT_V         1
`define CRS_BIT_C         0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CRS_RST_PC        16'hFFFD
`define CRS_RST_IL        2'h3

// ----------------------------------------------------------------------------
// Memory map (64 KiB)
// ----------------------------------------------------------------------------
`define CRS_IO_LAST       16'h007F
`define CRS_DIR_LAST      16'h00FF
`define CRS_GPR_BASE      16'h0100
`define CRS_GPR_LAST      16'h01FF
`define CRS_VEC_BASE      16'hFFC0
`define CRS_RAM_BASE      16'h0080
`define CRS_RAM_WORDS     384

// ----------------------------------------------------------------------------
// Region codes and operation codes
// ----------------------------------------------------------------------------
`define CRS_RGN_IO        3'h0
`define CRS_RGN_DIRECT    3'h1
`define CRS_RGN_GPR       3'h2
`define CRS_RGN_MAIN      3'h3
`define CRS_RGN_VECTOR    3'h4
`define CRS_OP_ADD        2'h0
`define CRS_OP_SUB        2'h1
`define CRS_OP_SHL        2'h2
`define CRS_OP_SHR        2'h3

`endif

// ### hw/crs_core.v
/*
 * Programmer-visible register set of an 8-bit core: dedicated 16-bit
 * registers, condition flags with their update logic, interrupt gating,
 * banked general registers in internal RAM and memory-space decode.
 * Assumes a classic Wishbone master on the same clock and an interrupt
 * requester that is synchronous to clk_i.
 */
// Local design decisions: the placing of the registers and the Wishbone slave port.
`include "crs_consts.vh"

// Overview of operation
// - Decode one 64 KiB space holding I/O, internal RAM and ROM.
// - Addresses 0x0000..0x007F are peripheral registers, also reachable directly.
// - RAM 0x80..0xFF is the fast direct-addressed area.
// - RAM 0x100..0x1FF holds the banked general registers.
// - Reset leaves internal RAM contents untouched and undefined.
// - Program counter is 16 bits, next instruction address, resets to 0xFFFD.
// - Accumulator and temporary are 16 bits; byte operations use low byte.
// - Index, extra and stack pointers are 16 bits, undefined after reset.
// - Status word: bank pointer in upper byte, condition flags in lower.
// - Reset clears interrupt enable and loads interrupt mask with 11.
// - Half carry marks carry out of bit 3 or borrow from bit 4.
// - Interrupts are accepted only while interrupt enable is one.
// - Interrupt taken only if its priority beats mask; 11 blocks only level 3.
// - Negative flag follows the result's most significant bit.
// - Zero flag set exactly when the result is zero.
// - Overflow flag marks two's complement overflow.
// - Carry marks carry or borrow at bit 7 (bit 15 in wide operations); shifts load shifted-out bit.
// - General registers are 8 bits, eight per bank, up to 16 banks.
// - Bank pointer selects the active bank for general register references.
module crs_core (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Interrupt request from a peripheral, same clock
    input  wire        irq_req_i,
    input  wire [1:0]  irq_level_i,
    output reg         irq_accept_o,
    // Region of the last decoded address
    output reg  [2:0]  region_o
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------

    // Classifies a 16-bit address into its memory region
    function [2:0] crs_region;
        input [15:0] addr;
        begin
            if (addr <= `CRS_IO_LAST) begin
                crs_region = `CRS_RGN_IO;
            end else if (addr <= `CRS_DIR_LAST) begin
                crs_region = `CRS_RGN_DIRECT;
            end else if (addr <= `CRS_GPR_LAST) begin
                crs_region = `CRS_RGN_GPR;
            end else if (addr >= `CRS_VEC_BASE) begin
                crs_region = `CRS_RGN_VECTOR;
            end else begin
                crs_region = `CRS_RGN_MAIN;
            end
        end
    endfunction

    // Merges the two low byte lanes of a write into a 16-bit register
    function [15:0] crs_lanes;
        input [15:0] old_val;
        input [15:0] new_val;
        input [1:0]  sel;
        begin
            crs_lanes = {sel[1] ? new_val[15:8] : old_val[15:8],
                         sel[0] ? new_val[7:0]  : old_val[7:0]};
        end
    endfunction

    // Turns a 16-bit memory address into an index of the RAM array
    function [8:0] crs_ram_index;
        input [15:0] addr;
        reg   [15:0] diff;
        begin
            diff          = addr - `CRS_RAM_BASE;
            crs_ram_index = diff[8:0];
        end
    endfunction

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg  [15:0] program_counter_ff;
    reg  [15:0] acc_ff;
    reg  [15:0] tmp_ff;
    reg  [15:0] index_reg_ff;
    reg  [15:0] extra_pointer_ff;
    reg  [15:0] stack_pointer_ff;
    reg  [7:0]  bank_pointer_ff;
    reg  [7:0]  condition_flags_byte_ff;
    reg  [15:0] dec_addr_ff;
    reg  [2:0]  gpr_num_ff;
    reg  [15:0] mem_addr_ff;
    reg  [7:0]  ram_mem [0:`CRS_RAM_WORDS-1];    // No reset: contents undefined

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr  = bus_req & wb_we_i;
    wire [15:0] wr_val  = wb_dat_i[15:0];
    wire [1:0]  wr_sel  = wb_sel_i[1:0];

    // ------------------------------------------------------------------------
    // Bank address
    // ------------------------------------------------------------------------

    // Sixteen banks of eight byte registers; the low nibble picks the bank
    wire [3:0]  bank_sel  = bank_pointer_ff[3:0];
    wire [15:0] gpr_addr  = `CRS_GPR_BASE + {9'h000, bank_sel, gpr_num_ff};
    wire [8:0]  gpr_index = crs_ram_index(gpr_addr);
    wire        mem_in_ram = (mem_addr_ff >= `CRS_RAM_BASE) && (mem_addr_ff <= `CRS_GPR_LAST);
    wire [8:0]  mem_index = crs_ram_index(mem_addr_ff);

    // ------------------------------------------------------------------------
    // Arithmetic unit and flag evaluation
    // ------------------------------------------------------------------------
    reg  [15:0] nxt_acc;
    reg  [7:0]  nxt_flags;
    reg  [16:0] sum;
    reg  [4:0]  half;
    reg         msb_a;
    reg         msb_t;
    reg         msb_r;
    reg         wide;
    reg  [1:0]  op;

    // Byte operations touch only the low byte; the high byte of A stays
    always @* begin
        sum       = 17'h00000;
        half      = 5'h00;
        msb_a     = 1'b0;
        msb_t     = 1'b0;
        msb_r     = 1'b0;
        op        = wb_dat_i[1:0];
        wide      = wb_dat_i[2];
        nxt_acc   = acc_ff;
        nxt_flags = condition_flags_byte_ff;
        case (op)
            `CRS_OP_ADD, `CRS_OP_SUB: begin
                if (op == `CRS_OP_ADD) begin
                    sum  = {1'b0, acc_ff} + {1'b0, tmp_ff};
                    half = {1'b0, acc_ff[3:0]} + {1'b0, tmp_ff[3:0]};
                end else begin
                    sum  = {1'b0, acc_ff} - {1'b0, tmp_ff};
                    half = {1'b0, acc_ff[3:0]} - {1'b0, tmp_ff[3:0]};
                end
                nxt_flags[`CRS_BIT_H] = half[4];
                if (wide) begin
                    nxt_acc = sum[15:0];
                    msb_a   = acc_ff[15];
                    msb_t   = tmp_ff[15] ^ (op == `CRS_OP_SUB);
                    msb_r   = sum[15];
                    nxt_flags[`CRS_BIT_C] = sum[16];
                end else begin
                    nxt_acc = {acc_ff[15:8], sum[7:0]};
                    msb_a   = acc_ff[7];
                    msb_t   = tmp_ff[7] ^ (op == `CRS_OP_SUB);
                    msb_r   = sum[7];
                    // Carry or borrow across bit 7 seen through the operand bits
                    nxt_flags[`CRS_BIT_C] = sum[8] ^ acc_ff[8] ^ tmp_ff[8];
                end
                nxt_flags[`CRS_BIT_V] = (msb_a == msb_t) && (msb_r != msb_a);
            end
            `CRS_OP_SHL: begin
                if (wide) begin
                    nxt_acc = {acc_ff[14:0], 1'b0};
                    nxt_flags[`CRS_BIT_C] = acc_ff[15];
                end else begin
                    nxt_acc = {acc_ff[15:8], acc_ff[6:0], 1'b0};
                    nxt_flags[`CRS_BIT_C] = acc_ff[7];
                end
                nxt_flags[`CRS_BIT_V] = 1'b0;
            end
            `CRS_OP_SHR: begin
                if (wide) begin
                    nxt_acc = {1'b0, acc_ff[15:1]};
                end else begin
                    nxt_acc = {acc_ff[15:8], 1'b0, acc_ff[7:1]};
                end
                nxt_flags[`CRS_BIT_C] = acc_ff[0];
                nxt_flags[`CRS_BIT_V] = 1'b0;
            end
            default: begin
                nxt_acc = acc_ff;
            end
        endcase
        if (wide) begin
            nxt_flags[`CRS_BIT_N] = nxt_acc[15];
            nxt_flags[`CRS_BIT_Z] = (nxt_acc == 16'h0000);
        end else begin
            nxt_flags[`CRS_BIT_N] = nxt_acc[7];
            nxt_flags[`CRS_BIT_Z] = (nxt_acc[7:0] == 8'h00);
        end
    end

    // ------------------------------------------------------------------------
    // Dedicated registers
    // ------------------------------------------------------------------------

    // Only the program counter and interrupt control have a reset value
    always @(posedge clk_i) begin
        if (rst_i) begin
            program_counter_ff <= `CRS_RST_PC;
            condition_flags_byte_ff[`CRS_BIT_I] <= 1'b0;
            condition_flags_byte_ff[`CRS_BIT_IL_HI:`CRS_BIT_IL_LO] <= `CRS_RST_IL;
        end else if (bus_wr) begin
            case (wb_adr_i)
                `CRS_OFS_PC: begin
                    program_counter_ff <= crs_lanes(program_counter_ff, wr_val, wr_sel);
                end
                `CRS_OFS_PSW: begin
                    if (wr_sel[0]) begin
                        condition_flags_byte_ff <= wr_val[7:0];
                    end
                end
                `CRS_OFS_ALU: begin
                    if (wr_sel[0]) begin
                        condition_flags_byte_ff <= nxt_flags;
                    end
                end
                default: begin
                    program_counter_ff <= program_counter_ff;
                end
            endcase
        end
    end

    // Data and pointer registers are left undefined by reset
    always @(posedge clk_i) begin
        if (bus_wr) begin
            case (wb_adr_i)
                `CRS_OFS_ACC:      acc_ff           <= crs_lanes(acc_ff, wr_val, wr_sel);
                `CRS_OFS_TMP:      tmp_ff           <= crs_lanes(tmp_ff, wr_val, wr_sel);
                `CRS_OFS_IDX:      index_reg_ff     <= crs_lanes(index_reg_ff, wr_val, wr_sel);
                `CRS_OFS_EXP:      extra_pointer_ff <= crs_lanes(extra_pointer_ff, wr_val, wr_sel);
                `CRS_OFS_STK:      stack_pointer_ff <= crs_lanes(stack_pointer_ff, wr_val, wr_sel);
                `CRS_OFS_DEC:      dec_addr_ff      <= crs_lanes(dec_addr_ff, wr_val, wr_sel);
                `CRS_OFS_MEM_ADDR: mem_addr_ff      <= crs_lanes(mem_addr_ff, wr_val, wr_sel);
                `CRS_OFS_PSW: begin
                    if (wr_sel[1]) begin
                        bank_pointer_ff <= wr_val[15:8];
                    end
                end
                `CRS_OFS_GPR_SEL: begin
                    if (wr_sel[0]) begin
                        gpr_num_ff <= wr_val[2:0];
                    end
                end
                `CRS_OFS_ALU: begin
                    if (wr_sel[0]) begin
                        acc_ff <= nxt_acc;
                    end
                end
                default: begin
                    acc_ff <= acc_ff;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Internal RAM
    // ------------------------------------------------------------------------

    // Writes outside 0x80..0x1FF through the memory window are dropped
    always @(posedge clk_i) begin
        if (bus_wr && wr_sel[0]) begin
            if (wb_adr_i == `CRS_OFS_GPR_DATA) begin
                ram_mem[gpr_index] <= wr_val[7:0];
            end else if ((wb_adr_i == `CRS_OFS_MEM_DATA) && mem_in_ram) begin
                ram_mem[mem_index] <= wr_val[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------------------

    // Ack one cycle after the request; unmapped offsets read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `CRS_OFS_PC:       wb_dat_o <= {16'h0000, program_counter_ff};
                    `CRS_OFS_ACC:      wb_dat_o <= {16'h0000, acc_ff};
                    `CRS_OFS_TMP:      wb_dat_o <= {16'h0000, tmp_ff};
                    `CRS_OFS_IDX:      wb_dat_o <= {16'h0000, index_reg_ff};
                    `CRS_OFS_EXP:      wb_dat_o <= {16'h0000, extra_pointer_ff};
                    `CRS_OFS_STK:      wb_dat_o <= {16'h0000, stack_pointer_ff};
                    `CRS_OFS_PSW:      wb_dat_o <= {16'h0000, bank_pointer_ff, condition_flags_byte_ff};
                    `CRS_OFS_DEC:      wb_dat_o <= {29'h00000000, crs_region(dec_addr_ff)};
                    `CRS_OFS_GPR_SEL:  wb_dat_o <= {16'h0000, gpr_addr};
                    `CRS_OFS_GPR_DATA: wb_dat_o <= {24'h000000, ram_mem[gpr_index]};
                    `CRS_OFS_MEM_ADDR: wb_dat_o <= {16'h0000, mem_addr_ff};
                    `CRS_OFS_MEM_DATA: wb_dat_o <= mem_in_ram ? {24'h000000, ram_mem[mem_index]} : 32'h00000000;
                    `CRS_OFS_IRQ:      wb_dat_o <= {31'h00000000, irq_accept_o};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt gating and region output
    // ------------------------------------------------------------------------

    // Level 0 is the highest priority, so a lower code must beat the mask
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_accept_o <= 1'b0;
            region_o     <= `CRS_RGN_IO;
        end else begin
            irq_accept_o <= irq_req_i
                          & condition_flags_byte_ff[`CRS_BIT_I]
                          & (irq_level_i < condition_flags_byte_ff[`CRS_BIT_IL_HI:`CRS_BIT_IL_LO]);
            region_o     <= crs_region(dec_addr_ff);
        end
    end

endmodule

// ### verif/cpu_register_set_and_flags_tb_top.sv
/* Self-checking bench for crs_core over classic Wishbone.
   Assumes crs_consts.vh on the include path and the checker bound. */
`include "crs_consts.vh"
module cpu_register_set_and_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus and observed signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        raise = 1'b0;
    logic [1:0]  lvl = 2'h0;
    logic        irq_req;
    logic [1:0]  irq_level;
    logic        irq_accept_o;
    logic [2:0]  region_o;
    logic [31:0] rd;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    crs_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_i(irq_req), .irq_level_i(irq_level),
        .irq_accept_o(irq_accept_o), .region_o(region_o));
    crs_irq_src u_src (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .level_i(lvl),
        .irq_req_o(irq_req), .irq_level_o(irq_level));

    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Ack is read before the edge's updates land, so no race
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, 4'h3, dat);
    endtask
    task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 4'h3, 32'h0);
        chk(what, exp, rd);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdc("pc", `CRS_OFS_PC, 32'h0000FFFD);
        wb(1'b0, `CRS_OFS_PSW, 4'h3, 32'h0);
        chk("enable and mask", 32'h00000030, rd & 32'h00000070);
    endtask
    // Byte lanes and upper data bits must not leak
    task automatic t_regs();
        logic [7:0] ofs [5] = '{`CRS_OFS_ACC, `CRS_OFS_TMP, `CRS_OFS_IDX, `CRS_OFS_EXP, `CRS_OFS_STK};
        foreach (ofs[i]) begin
            wr(ofs[i], 32'hFFFFA500 | i);
            wb(1'b1, ofs[i], 4'h2, 32'h00003C77);
            rdc("register", ofs[i], 32'h00003C00 | i);
        end
        wr(`CRS_OFS_PSW, 32'h00005A30);
        wb(1'b1, `CRS_OFS_PSW, 4'h1, 32'h0000FF70);
        rdc("status word", `CRS_OFS_PSW, 32'h00005A70);
        wr(8'h3C, 32'h0000FFFF);
        rdc("unmapped", 8'h3C, 32'h0);
    endtask
    // Fields: acc, temp, op, result, flags
    task automatic t_alu();
        logic [59:0] tab [12] = '{60'h120F_0001_0_1210_B0, 60'h127F_0001_0_1280_BA,
            60'h12FF_0001_0_1200_B5, 60'h1210_0001_1_120F_B0, 60'h1200_0001_1_12FF_B9,
            60'h1280_0001_1_127F_B2, 60'h1281_0000_2_1202_31, 60'h1201_0000_3_1200_35,
            60'h7FFF_0001_4_8000_BA, 60'h8000_0001_5_7FFF_B2, 60'h8001_0000_6_0002_31,
            60'h0001_0000_7_0000_35};
        foreach (tab[i]) begin
            wr(`CRS_OFS_ACC, {16'h0, tab[i][59:44]});
            wr(`CRS_OFS_TMP, {16'h0, tab[i][43:28]});
            wr(`CRS_OFS_PSW, 32'h00000030);
            wr(`CRS_OFS_ALU, {28'h0, tab[i][27:24]});
            rdc("result", `CRS_OFS_ACC, {16'h0, tab[i][23:8]});
            wb(1'b0, `CRS_OFS_PSW, 4'h1, 32'h0);
            chk("flags", {24'h0, tab[i][7:0]}, rd & 32'h000000FF);
        end
    endtask
    // Extreme banks and registers; upper pointer bits must not alter the address
    task automatic t_bank();
        logic [3:0] bk;
        logic [2:0] rn;
        for (int p = 0; p < 4; p++) begin
            bk = p[0] ? 4'hF : 4'h0;
            rn = p[0] ? 3'h7 : 3'h0;
            wr(`CRS_OFS_PSW, {16'h0, 4'hA, bk, 8'h30});
            wr(`CRS_OFS_GPR_SEL, {29'h0, rn});
            if (p < 2) begin
                rdc("bank address", `CRS_OFS_GPR_SEL, 32'(256 + 8 * bk + rn));
                wr(`CRS_OFS_GPR_DATA, {24'h0, 8'hC3 ^ {4'h0, bk}});
            end else begin
                rdc("bank data", `CRS_OFS_GPR_DATA, {24'h0, 8'hC3 ^ {4'h0, bk}});
                wr(`CRS_OFS_MEM_ADDR, 32'(256 + 8 * bk + rn));
                rdc("bank in ram", `CRS_OFS_MEM_DATA, {24'h0, 8'hC3 ^ {4'h0, bk}});
            end
        end
    endtask
    task automatic t_decode();
        logic [15:0] da [10] = '{16'h0000, 16'h007F, 16'h0080, 16'h00FF, 16'h0100,
            16'h01FF, 16'h0200, 16'hFFBF, 16'hFFC0, 16'hFFFF};
        logic [2:0] dc [10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
        foreach (da[i]) begin
            wr(`CRS_OFS_DEC, {16'h0, da[i]});
            rdc("decode", `CRS_OFS_DEC, {29'h0, dc[i]});
            chk("region", {29'h0, dc[i]}, {29'h0, region_o});
        end
    endtask
    // Fields: flags byte, level, expected accept
    task automatic t_irq();
        logic [15:0] it [6] = '{16'h3000, 16'h6011, 16'h6020, 16'h7001, 16'h7030, 16'h5001};
        foreach (it[i]) begin
            wr(`CRS_OFS_PSW, {24'h0, it[i][15:8]});
            raise <= 1'b1;
            lvl   <= it[i][5:4];
            repeat (3) @(posedge clk_i);
            chk("accept", {31'h0, it[i][0]}, {31'h0, irq_accept_o});
            rdc("accept reg", `CRS_OFS_IRQ, {31'h0, it[i][0]});
            raise <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // Reset in mid-run must leave RAM alone
    task automatic t_ram();
        wr(`CRS_OFS_MEM_ADDR, 32'h00000080);
        wr(`CRS_OFS_MEM_DATA, 32'h0000005C);
        rdc("direct ram", `CRS_OFS_MEM_DATA, 32'h0000005C);
        wr(`CRS_OFS_MEM_ADDR, 32'h00000200);
        wr(`CRS_OFS_MEM_DATA, 32'h000000AA);
        rdc("outside ram", `CRS_OFS_MEM_DATA, 32'h0);
        wr(`CRS_OFS_PC, 32'h00001234);
        rdc("pc write", `CRS_OFS_PC, 32'h00001234);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        wr(`CRS_OFS_MEM_ADDR, 32'h00000080);
        rdc("ram kept", `CRS_OFS_MEM_DATA, 32'h0000005C);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_alu();
        t_bank();
        t_decode();
        t_irq();
        t_ram();
        tally_and_finish();
    end
endmodule

// ### verif/crs_core_asserts.sv
/* Checker for the bus handshake, reset outputs and interrupt gating of crs_core.
   Assumes it is bound to crs_core and that everything runs on clk_i. */
module crs_core_asserts (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Interrupt and decode
    input wire        irq_req_i,
    input wire [1:0]  irq_level_i,
    input wire        irq_accept_o,
    input wire [2:0]  region_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Handshake steps
    // ----------------------------------------------------------------
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i) s_taken |=> s_answer)
        else $error("ack not a single pulse one cycle after request");
    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    read_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data driven outside an answer");
    reset_outs_a: assert property (@(posedge clk_i) rst_i |=> !wb_ack_o && !irq_accept_o && region_o == 3'h0)
        else $error("outputs not cleared by reset");
    irq_reset_a: assert property (@(posedge clk_i) $fell(rst_i) |-> !irq_accept_o [*2])
        else $error("interrupt accepted before enable was set");
    irq_noreq_a: assert property (@(posedge clk_i) disable iff (rst_i) !irq_req_i |=> !irq_accept_o)
        else $error("accept without request");
    irq_lowest_a: assert property (@(posedge clk_i) disable iff (rst_i) irq_level_i == 2'h3 |=> !irq_accept_o)
        else $error("lowest level request accepted");
    region_code_a: assert property (@(posedge clk_i) disable iff (rst_i) region_o <= 3'h4)
        else $error("region code out of range");
endmodule

bind crs_core crs_core_asserts u_chk (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .irq_req_i    (irq_req_i),
    .irq_level_i  (irq_level_i),
    .irq_accept_o (irq_accept_o),
    .region_o     (region_o)
);

// ### verif/crs_irq_src.sv
/* Model of a peripheral raising interrupt requests at a chosen level.
   Assumes commands from the bench on the core clock. */
module crs_irq_src (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Command from the bench
    input  wire       raise_i,
    input  wire [1:0] level_i,
    // Request toward the core
    output reg        irq_req_o,
    output reg  [1:0] irq_level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Level wanders while idle, so a stale level never looks valid
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_o   <= 1'b0;
            irq_level_o <= 2'h0;
        end else begin
            irq_req_o   <= raise_i;
            irq_level_o <= raise_i ? level_i : irq_level_o + 2'h1;
        end
    end
endmodule
